// ===== hw/sfb_dev.sv
// sfb_dev: memory end of the serial bus, bus sampled on i_mclk
// assumes: sck no faster than i_mclk/8; bus pins asynchronous
// so is released (so_oe_n high) whenever deselected or in reset
`timescale 1ns/100ps
module sfb_dev #(
  parameter bit BIN_PAGE_OPT = 1'b0
) (
  input  wire logic       i_mclk,
  input  wire logic       i_nrst,
  sfb_if.dev              bus,
  input  wire logic       i_cfg_bin,
  input  wire logic [7:0] i_rd_data,
  output logic            o_cmd_vld,
  output logic [7:0]      o_cmd,
  output logic [7:0]      o_wr_data,
  output logic            o_wr_vld,
  output logic            o_rd_req,
  output logic [8:0]      o_page_size
);
  import sfb_pkg::*;

  typedef enum logic [1:0] {SFB_CMD, SFB_ADDR, SFB_DATA} sfb_ph_t;

  // --------------------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------------------
  // three stages; sck, cs_n and rst_n levels count once the last two agree, si is taken from the last stage
  logic [2:0] sck_s, cs_s, si_s, rn_s;
  logic       sck_q, cs_q, rn_q;
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      sck_s <= 3'h0;
      cs_s  <= 3'h7;
      si_s  <= 3'h0;
      rn_s  <= 3'h0;
      sck_q <= 1'b0;
      cs_q  <= 1'b1;
      rn_q  <= 1'b0;
    end else begin
      sck_s <= {sck_s[1:0], bus.sck};
      cs_s  <= {cs_s[1:0], bus.cs_n};
      si_s  <= {si_s[1:0], bus.si};
      rn_s  <= {rn_s[1:0], bus.rst_n};
      if (sck_s[1] == sck_s[2]) sck_q <= sck_s[2];
      if (cs_s[1] == cs_s[2])   cs_q  <= cs_s[2];
      if (rn_s[1] == rn_s[2])   rn_q  <= rn_s[2];
    end
  end

  // edges from agreed levels only, so idle low or high both work
  wire sck_ok   = (sck_s[1] == sck_s[2]);
  wire rise     = sck_ok & sck_s[2] & ~sck_q;
  wire fall     = sck_ok & ~sck_s[2] & sck_q;
  wire selected = ~cs_q & rn_q;
  wire bit_in   = si_s[2];

  // --------------------------------------------------------------
  // decode
  // --------------------------------------------------------------
  // status and id reads carry no address bytes
  function automatic logic [1:0] addr_bytes(input logic [7:0] op);
    case (op)
      OP_STAT_RD, OP_ID_RD: addr_bytes = 2'd0;
      default:              addr_bytes = 2'd3;
    endcase
  endfunction

  function automatic logic [7:0] reg_byte(input logic [7:0] op, input logic [7:0] st, input logic n);
    case (op)
      OP_SPR_RD:  reg_byte = DEF_SPR;
      OP_SLD_RD:  reg_byte = DEF_SLD;
      OP_SEC_RD:  reg_byte = DEF_SEC;
      OP_STAT_RD: reg_byte = st;
      OP_ID_RD:   reg_byte = n ? ID_DEV : ID_MFR;
      default:    reg_byte = 8'h00;
    endcase
  endfunction

  // opcode classes
  logic [7:0] op;
  wire is_arr = (op == OP_CAR) | (op == OP_CAR_OLD) | (op == OP_CAR_LF);
  wire is_pg  = (op == OP_PG_RD);
  wire is_buf = (op == OP_B1_RD) | (op == OP_B2_RD) | (op == OP_B1_RD_LF)
              | (op == OP_B2_RD_LF);
  wire is_reg = (op == OP_SPR_RD) | (op == OP_SLD_RD) | (op == OP_SEC_RD)
              | (op == OP_STAT_RD) | (op == OP_ID_RD);
  wire is_wr  = (op == OP_BUF_WR) | (op == OP_PG_PROG);
  wire is_rd  = is_arr | is_pg | is_buf | is_reg;

  // --------------------------------------------------------------
  // shifter
  // --------------------------------------------------------------
  sfb_ph_t    ph;
  logic [2:0] bitn;
  logic [1:0] abytes;
  logic [7:0] sh_in, sh_out;
  logic       drive, so_rel, page_bin;
  wire  [7:0] next_in  = {sh_in[6:0], bit_in};
  wire  [7:0] status   = STAT_RDY | STAT_BASE | (page_bin ? STAT_BIN_BIT : 8'h00);
  // second id byte once the first is already on the wire
  wire  [7:0] next_rd  = is_reg ? reg_byte(op, status, drive) : i_rd_data;
  wire        byte_end = rise & (bitn == BIT_LAST);
  wire        rd_load  = fall & (ph == SFB_DATA) & is_rd & (bitn == 3'h0);

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      ph     <= SFB_CMD;
      bitn   <= 3'h0;
      op     <= 8'h00;
      abytes <= 2'd0;
      sh_in  <= 8'h00;
      sh_out <= 8'h00;
      drive  <= 1'b0;
      so_rel <= 1'b1;
    end else if (!selected) begin
      ph     <= SFB_CMD;
      bitn   <= 3'h0;
      drive  <= 1'b0;
      so_rel <= 1'b1;
    end else begin
      if (rise) begin
        sh_in <= next_in;
        bitn  <= bitn + 3'h1;
      end
      if (byte_end) begin
        case (ph)
          SFB_CMD: begin
            op     <= next_in;
            abytes <= addr_bytes(next_in);
            ph     <= (addr_bytes(next_in) == 2'd0) ? SFB_DATA : SFB_ADDR;
          end
          SFB_ADDR: begin
            abytes <= abytes - 2'd1;
            if (abytes == 2'd1) ph <= SFB_DATA;
          end
          default: ph <= SFB_DATA;
        endcase
      end
      if (fall) begin
        if (rd_load) begin
          sh_out <= next_rd;
          drive  <= 1'b1;
          so_rel <= 1'b0;
        end else if (drive) begin
          sh_out <= {sh_out[6:0], 1'b0};
        end
      end
    end
  end

  // --------------------------------------------------------------
  // page size and user outputs
  // --------------------------------------------------------------
  // cmd and write strobes land the cycle after the edge that ends a byte, o_rd_req the cycle after the fall that loads an array, page or buffer read byte
  wire cmd_end  = selected & byte_end & (ph == SFB_CMD);
  wire data_end = selected & byte_end & (ph == SFB_DATA);
  wire arr_load = selected & rd_load & ~is_reg;

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      page_bin    <= BIN_PAGE_OPT;
      o_cmd_vld   <= 1'b0;
      o_cmd       <= 8'h00;
      o_wr_data   <= 8'h00;
      o_wr_vld    <= 1'b0;
      o_rd_req    <= 1'b0;
      o_page_size <= BIN_PAGE_OPT ? PAGE_BIN : PAGE_STD;
    end else begin
      // ordered option comes back whenever the reset pin is low
      if (!rn_q) page_bin <= BIN_PAGE_OPT;
      else if (i_cfg_bin) page_bin <= 1'b1;
      o_page_size <= page_bin ? PAGE_BIN : PAGE_STD;
      o_cmd_vld   <= cmd_end;
      o_cmd       <= cmd_end ? next_in : o_cmd;
      o_wr_vld    <= data_end & is_wr;
      o_wr_data   <= (selected & byte_end) ? next_in : o_wr_data;
      o_rd_req    <= arr_load;
    end
  end

  // --------------------------------------------------------------
  // bus outputs, both straight from flops
  // --------------------------------------------------------------
  assign bus.so_out  = sh_out[7];
  assign bus.so_oe_n = so_rel;
endmodule

// ===== hw/sfb_host.sv
// sfb_host: host end, generates sck from i_mclk by a divider
// assumes: one transfer request at a time, user waits o_done
`timescale 1ns/100ps
module sfb_host (
  input  wire logic       i_mclk,
  input  wire logic       i_nrst,
  sfb_if.host             bus,
  input  wire logic       i_start,
  input  wire logic [7:0] i_op,
  input  wire logic [23:0] i_addr,
  input  wire logic       i_use_addr,
  input  wire logic [7:0] i_nrd,
  input  wire logic       i_wr_page,
  output logic            o_done,
  output logic            o_rd_vld,
  output logic [7:0]      o_rd_data,
  output logic            o_refresh_due,
  output logic [10:0]     o_refresh_page,
  output logic            o_busy
);
  import sfb_pkg::*;

  typedef enum logic [1:0] {SFH_RST, SFH_IDLE, SFH_XFER, SFH_END} sfh_st_t;

  sfh_st_t     st;
  logic [15:0] rcnt;
  logic [3:0]  div;
  logic [31:0] tx;
  logic [5:0]  txbits;
  logic [7:0]  rx, rdleft;
  logic [2:0]  rxbit;
  logic        sck, cs_n, si, rst_n, rx_arm;
  logic [2:0]  so_s;
  logic [13:0] wcnt;
  wire  tick  = (div == SCK_HALF);
  wire  t_rise = tick & ~sck;
  wire  t_fall = tick & sck;
  wire  so_in  = so_s[2];
  // released line seen inverted, so a late drive shows up
  wire  so_pin = bus.so_out ^ bus.so_oe_n;

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) so_s <= 3'h0;
    else so_s <= {so_s[1:0], so_pin};
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      st <= SFH_RST; rcnt <= 16'h0000; div <= 4'h0; tx <= 32'h0000_0000;
      txbits <= 6'd0; rx <= 8'h00; rdleft <= 8'h00; rxbit <= 3'h0;
      sck <= 1'b0; cs_n <= 1'b1; si <= 1'b0; rst_n <= 1'b0; rx_arm <= 1'b0;
      o_done <= 1'b0; o_rd_vld <= 1'b0; o_rd_data <= 8'h00; o_busy <= 1'b1;
    end else begin
      o_done   <= 1'b0;
      o_rd_vld <= 1'b0;
      div      <= tick ? 4'h0 : div + 4'h1;
      case (st)
        SFH_RST: begin
          cs_n <= 1'b1;
          rcnt <= rcnt + 16'h0001;
          if (rcnt == RST_CYC) begin
            rst_n <= 1'b1;
            st <= SFH_IDLE;
            o_busy <= 1'b0;
          end
        end
        SFH_IDLE: begin
          sck <= 1'b0;
          if (i_start) begin
            cs_n   <= 1'b0;
            tx     <= i_use_addr ? {i_op, i_addr} : {i_op, 24'h00_0000};
            txbits <= i_use_addr ? 6'd32 : 6'd8;
            rdleft <= i_nrd;
            rxbit  <= 3'h0;
            rx_arm <= 1'b0;
            div    <= 4'h0;
            o_busy <= 1'b1;
            st     <= SFH_XFER;
          end
        end
        SFH_XFER: begin
          if (tick) sck <= ~sck;
          if (t_rise && txbits != 6'd0) begin
            si     <= tx[31];
            tx     <= {tx[30:0], 1'b0};
            txbits <= txbits - 6'd1;
          end
          if (t_fall) begin
            if (rx_arm) begin
              rx    <= {rx[6:0], so_in};
              rxbit <= rxbit + 3'h1;
              if (rxbit == BIT_LAST) begin
                o_rd_vld  <= 1'b1;
                o_rd_data <= {rx[6:0], so_in};
                rdleft    <= rdleft - 8'h01;
              end
            end
            if (txbits == 6'd0) rx_arm <= 1'b1;
            if (txbits == 6'd0 && (rdleft == 8'h00 || (rx_arm && rxbit == BIT_LAST && rdleft == 8'h01)))
              st <= SFH_END;
          end
        end
        default: begin
          sck <= 1'b0;
          cs_n <= 1'b1;
          o_done <= 1'b1;
          o_busy <= 1'b0;
          st <= SFH_IDLE;
        end
      endcase
    end
  end

  // --------------------------------------------------------------
  // refresh pointer and rewrite span
  // --------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      wcnt <= 14'h0000; o_refresh_page <= 11'h000; o_refresh_due <= 1'b0;
    end else if (i_start && st == SFH_IDLE && i_op == OP_REWRITE) begin
      o_refresh_page <= (o_refresh_page == PAGE_LAST) ? 11'h000 : o_refresh_page + 11'h001;
      o_refresh_due  <= 1'b0;
    end else if (i_start && st == SFH_IDLE && (i_wr_page || i_op == OP_BUF_PROG)) begin
      wcnt <= (wcnt == REWRITE_SPAN_CNT - 14'h0001) ? 14'h0000 : wcnt + 14'h0001;
      if (wcnt == REWRITE_SPAN_CNT - 14'h0001) o_refresh_due <= 1'b1;
    end
  end

  assign bus.sck   = sck;
  assign bus.cs_n  = cs_n;
  assign bus.si    = si;
  assign bus.rst_n = rst_n;
endmodule

// ===== hw/sfb_if.sv
// sfb_if: serial bus wires between host and memory
// assumes: host end resolves so from the memory's enable
`timescale 1ns/100ps
interface sfb_if;
  logic sck;
  logic cs_n;
  logic si;
  logic so_out;
  logic so_oe_n;
  logic rst_n;
  modport dev  (input sck, input cs_n, input si, input rst_n, output so_out, output so_oe_n);
  modport host (output sck, output cs_n, output si, output rst_n, input so_out, input so_oe_n);
endinterface

// ===== hw/sfb_pkg.sv
// sfb_pkg: shared constants for the serial flash bus port
// assumes: included before the interface and both end modules
package sfb_pkg;
  localparam logic [7:0] OP_CAR      = 8'h0B;
  localparam logic [7:0] OP_CAR_OLD  = 8'hE8;
  localparam logic [7:0] OP_CAR_LF   = 8'h03;
  localparam logic [7:0] OP_PG_RD    = 8'hD2;
  localparam logic [7:0] OP_B1_RD    = 8'hD4;
  localparam logic [7:0] OP_B2_RD    = 8'hD6;
  localparam logic [7:0] OP_B1_RD_LF = 8'hD1;
  localparam logic [7:0] OP_B2_RD_LF = 8'hD3;
  localparam logic [7:0] OP_SPR_RD   = 8'h32;
  localparam logic [7:0] OP_SLD_RD   = 8'h35;
  localparam logic [7:0] OP_SEC_RD   = 8'h77;
  localparam logic [7:0] OP_STAT_RD  = 8'hD7;
  localparam logic [7:0] OP_ID_RD    = 8'h9F;
  localparam logic [7:0] OP_PG_PROG  = 8'h82;
  localparam logic [7:0] OP_BUF_WR   = 8'h84;
  localparam logic [7:0] OP_BUF_PROG = 8'h83;
  localparam logic [7:0] OP_REWRITE  = 8'h58;
  localparam logic [8:0] PAGE_STD    = 9'h0108;
  localparam logic [8:0] PAGE_BIN    = 9'h0100;
  localparam logic [7:0] STAT_BIN_BIT = 8'h01;
  localparam logic [7:0] STAT_RDY     = 8'h80;
  localparam logic [7:0] STAT_BASE    = 8'h1C;
  localparam logic [7:0] ID_MFR       = 8'h5A; // arbitrary
  localparam logic [7:0] ID_DEV       = 8'hA5; // arbitrary
  localparam logic [7:0] DEF_SPR      = 8'h00;
  localparam logic [7:0] DEF_SLD      = 8'h00;
  localparam logic [7:0] DEF_SEC      = 8'h3C;
  localparam int unsigned REWRITE_SPAN = 10000;
  localparam logic [13:0] REWRITE_SPAN_CNT = 14'(REWRITE_SPAN);
  localparam logic [10:0] PAGE_LAST   = 11'h07FF;
  localparam logic [3:0]  SCK_HALF    = 4'h3;
  localparam logic [2:0]  BIT_LAST    = 3'h7;
  localparam logic [15:0] RST_CYC     = 16'h0400;
endpackage

// ===== tb/sfb_properties.sv
// sfb_properties: wire-level checks between host end and memory end
// assumes: fed from the joining interface, single i_mclk domain
`timescale 1ns/100ps
module sfb_properties (
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  input wire logic so_oe_n,
  input wire logic rst_n
);
  // ----------------------------------------
  // rise counting within a frame
  // ----------------------------------------
  logic       sck_d;
  logic       past8;
  logic [2:0] bit_cnt;
  wire        sck_up = sck & ~sck_d;
  wire  [2:0] next_bit_cnt = cs_n ? 3'h0 : bit_cnt + {2'h0, sck_up};
  wire        next_past8 = !cs_n && (past8 || (sck_up && bit_cnt == 3'h7));

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      sck_d   <= 1'b0;
      past8   <= 1'b0;
      bit_cnt <= 3'h0;
    end else begin
      sck_d   <= sck;
      past8   <= next_past8;
      bit_cnt <= next_bit_cnt;
    end
  end

  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_nrst);

  sequence s_frame_end;
    $rose(cs_n);
  endsequence
  sequence s_high_half;
    sck [*3];
  endsequence

  property p_sel_quiet;
    cs_n [*8] |-> so_oe_n;
  endproperty
  a_sel_quiet: assert property (p_sel_quiet) else $error("output driven while deselected");
  property p_rst_quiet;
    !rst_n [*4] |-> so_oe_n;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("output driven in reset");
  property p_rst_order;
    $rose(rst_n) |-> cs_n && $past(cs_n);
  endproperty
  a_rst_order: assert property (p_rst_order) else $error("reset released with select low");
  property p_first_drive;
    $fell(so_oe_n) |-> past8 && !cs_n;
  endproperty
  a_first_drive: assert property (p_first_drive) else $error("output driven before command done");
  property p_release;
    s_frame_end |-> ##[0:8] so_oe_n;
  endproperty
  a_release: assert property (p_release) else $error("output not released after select");
  property p_si_launch;
    !cs_n && !$past(cs_n) && $changed(si) && (past8 || bit_cnt != 3'h0) |-> sck;
  endproperty
  a_si_launch: assert property (p_si_launch) else $error("host data changed in clock low phase");
  property p_high_half;
    $rose(sck) |-> s_high_half;
  endproperty
  a_high_half: assert property (p_high_half) else $error("clock high phase too short");
  property p_low_half;
    $fell(sck) && !cs_n |-> !sck [*3];
  endproperty
  a_low_half: assert property (p_low_half) else $error("clock low phase too short");
  property p_whole_bytes;
    s_frame_end |-> bit_cnt == 3'h0;
  endproperty
  a_whole_bytes: assert property (p_whole_bytes) else $error("frame ended mid byte");
endmodule

// ===== tb/tb_serial_flash_bus_port.sv
// tb_serial_flash_bus_port: both ends joined, reads checked end to end
// assumes: package, interface and both end modules compiled first
`timescale 1ns/100ps
module tb_serial_flash_bus_port;
  import sfb_pkg::*;
  localparam logic [7:0] RDV = 8'hA6;
  logic        i_mclk, i_nrst, i_start, i_use_addr, i_cfg_bin;
  logic [7:0]  i_op, i_nrd, last_cmd, o_rd_data, o_cmd;
  logic        o_done, o_rd_vld, o_cmd_vld, o_busy, o_refresh_due;
  logic [8:0]  o_page_size, bin_size;
  logic [10:0] o_refresh_page;
  logic [7:0]  rd_q[$];
  int          n_fail = 0;
  int          checks_done = 0;
  int          cyc = 0;
  logic [7:0]  ops [11] = '{OP_CAR, OP_CAR_OLD, OP_CAR_LF, OP_PG_RD, OP_B1_RD, OP_B2_RD, OP_B1_RD_LF,
                            OP_B2_RD_LF, OP_SPR_RD, OP_SLD_RD, OP_SEC_RD};
  logic [7:0]  exps [11] = '{RDV, RDV, RDV, RDV, RDV, RDV, RDV, RDV, DEF_SPR, DEF_SLD, DEF_SEC};

  sfb_if bus();
  sfb_if bus2();
  assign bus2.sck = 1'b0;
  assign bus2.cs_n = 1'b1;
  assign bus2.si = 1'b0;
  assign bus2.rst_n = 1'b1;

  sfb_dev sfb_dev_i (.i_mclk(i_mclk), .i_nrst(i_nrst), .bus(bus), .i_cfg_bin(i_cfg_bin), .i_rd_data(RDV),
    .o_cmd_vld(o_cmd_vld), .o_cmd(o_cmd), .o_wr_data(), .o_wr_vld(), .o_rd_req(), .o_page_size(o_page_size));
  sfb_dev #(.BIN_PAGE_OPT(1'b1)) sfb_dev_bin_i (.i_mclk(i_mclk), .i_nrst(i_nrst), .bus(bus2), .i_cfg_bin(1'b0),
    .i_rd_data(8'h00), .o_cmd_vld(), .o_cmd(), .o_wr_data(), .o_wr_vld(), .o_rd_req(), .o_page_size(bin_size));
  sfb_host sfb_host_i (.i_mclk(i_mclk), .i_nrst(i_nrst), .bus(bus), .i_start(i_start), .i_op(i_op),
    .i_addr(24'h00_0040), .i_use_addr(i_use_addr), .i_nrd(i_nrd), .i_wr_page(1'b0), .o_done(o_done),
    .o_rd_vld(o_rd_vld), .o_rd_data(o_rd_data), .o_refresh_due(o_refresh_due),
    .o_refresh_page(o_refresh_page), .o_busy(o_busy));
  sfb_properties sfb_properties_i (.i_mclk(i_mclk), .i_nrst(i_nrst), .sck(bus.sck), .cs_n(bus.cs_n),
    .si(bus.si), .so_oe_n(bus.so_oe_n), .rst_n(bus.rst_n));

  // ----------------------------------------
  // clock, monitor, hang guard
  // ----------------------------------------
  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end
  always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    if (o_cmd_vld === 1'b1) last_cmd <= o_cmd;
    if (o_rd_vld === 1'b1) rd_q.push_back(o_rd_data);
    if (cyc == 20000) begin
      n_fail++;
      print_verdict();
    end
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic cmp_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cmp_word(input string what, input logic [10:0] exp, input logic [10:0] got);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // one host transfer, waits for its completion pulse
  task automatic run(input logic [7:0] op, input logic ua, input logic [7:0] nrd);
    last_cmd = 8'h00;
    rd_q.delete();
    while (o_busy !== 1'b0) @(negedge i_mclk);
    i_op = op;
    i_use_addr = ua;
    i_nrd = nrd;
    i_start = 1'b1;
    @(negedge i_mclk);
    i_start = 1'b0;
    while (o_done !== 1'b1) @(negedge i_mclk);
    @(negedge i_mclk);
    cmp_byte("opcode", op, last_cmd);
    cmp_word("byte count", 11'(nrd), 11'(rd_q.size()));
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    i_nrst = 1'b0;
    i_start = 1'b0;
    i_op = 8'h00;
    i_use_addr = 1'b0;
    i_nrd = 8'h00;
    i_cfg_bin = 1'b0;
    repeat (20) @(negedge i_mclk);
    i_nrst = 1'b1;
    @(negedge i_mclk);
    cmp_word("page size", 11'(PAGE_STD), 11'(o_page_size));
    cmp_word("bin option page size", 11'(PAGE_BIN), 11'(bin_size));
    cmp_word("refresh page", 11'h000, o_refresh_page);
    for (int k = 0; k < 11; k++) begin
      run(ops[k], 1'b1, 8'h01);
      cmp_byte("read byte", exps[k], rd_q[0]);
    end
    run(OP_ID_RD, 1'b0, 8'h02);
    cmp_byte("id first", ID_MFR, rd_q[0]);
    cmp_byte("id second", ID_DEV, rd_q[1]);
    run(OP_STAT_RD, 1'b0, 8'h01);
    cmp_byte("status", STAT_RDY | STAT_BASE, rd_q[0]);
    i_cfg_bin = 1'b1;
    run(OP_STAT_RD, 1'b0, 8'h01);
    cmp_byte("status bin", STAT_RDY | STAT_BASE | STAT_BIN_BIT, rd_q[0]);
    cmp_word("page size bin", 11'(PAGE_BIN), 11'(o_page_size));
    run(OP_REWRITE, 1'b1, 8'h00);
    cmp_word("refresh page", 11'h001, o_refresh_page);
    cmp_word("refresh due", 11'h000, 11'(o_refresh_due));
    print_verdict();
  end
endmodule
